// ==== src/rdci_pkg.sv ====
// constants for the receive completion status and interrupt enable block
package rdci_pkg;
	localparam int RDCI_DW = 32;
	localparam int RDCI_ADR_W = 8;
	localparam int RDCI_SEL_W = 4;
	localparam int RDCI_NCH = 4;
	localparam int RDCI_CNT_W = 16;
	localparam logic [RDCI_ADR_W-1:0] RDCI_OFS_MASKED = 8'h00;
	localparam logic [RDCI_ADR_W-1:0] RDCI_OFS_RAW = 8'h04;
	localparam logic [RDCI_ADR_W-1:0] RDCI_OFS_EN_SET = 8'h08;
	localparam logic [RDCI_ADR_W-1:0] RDCI_OFS_EN_CLR = 8'h0C;
	localparam logic [RDCI_ADR_W-1:0] RDCI_OFS_BUFCNT0 = 8'h10;
	localparam logic [RDCI_NCH-1:0] RDCI_RAW_RST = 4'h0;
	localparam logic [RDCI_NCH-1:0] RDCI_EN_RST = 4'h0;
	localparam logic [RDCI_CNT_W-1:0] RDCI_CNT_RST = 16'h0000;
	localparam logic [RDCI_DW-1:0] RDCI_DAT_RST = 32'h0000_0000;
endpackage : rdci_pkg

// ==== src/rdci_top.sv ====
// receive completion flags, interrupt enables and channel 0 buffer counter
//
// Operation
// - sticky raw done flag per channel 3..0
// - masked status is raw AND enable
// - four enables, one per status bit
// - enable-set write: ones set enables
// - enable-clear write: ones clear enables
// - 16-bit buffer count, writes add
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
module rdci_top #(
	parameter int NCH = rdci_pkg::RDCI_NCH,
	parameter int CNT_W = rdci_pkg::RDCI_CNT_W
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [rdci_pkg::RDCI_ADR_W-1:0] wb_adr_i,
	input wire logic [rdci_pkg::RDCI_SEL_W-1:0] wb_sel_i,
	input wire logic [rdci_pkg::RDCI_DW-1:0] wb_dat_i,
	output logic [rdci_pkg::RDCI_DW-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [NCH-1:0] rx_done_i,
	input wire logic rx_buf_take_i,
	output logic [CNT_W-1:0] rx_buf_count_o,
	output logic irq_o
);
	import rdci_pkg::*;

	// raw completion flags, one per channel
	logic [NCH-1:0] raw_r;
	logic [NCH-1:0] raw_nxt;

	// enables double as the interrupt mask
	logic [NCH-1:0] en_r;
	logic [NCH-1:0] en_nxt;

	// channel 0 free buffer count
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic [CNT_W-1:0] cnt_added;
	logic take_ok;

	// bus answer
	logic ack_r;
	logic ack_nxt;
	logic [RDCI_DW-1:0] dat_r;
	logic [RDCI_DW-1:0] dat_nxt;

	// interrupt line
	logic irq_r;
	logic irq_nxt;

	// decoded request
	logic req;
	logic wr;
	logic rd;
	logic [RDCI_DW-1:0] wdat;
	logic [NCH-1:0] wdat_ch;
	logic [CNT_W-1:0] wdat_cnt;
	logic sel_masked;
	logic sel_raw;
	logic sel_en_set;
	logic sel_en_clr;
	logic sel_cnt;
	logic wr_raw;
	logic wr_en_set;
	logic wr_en_clr;
	logic wr_cnt;

	// read source picked once, so the read mux is a plain case
	typedef enum logic [2:0] {
		RSRC_NONE,
		RSRC_MASKED,
		RSRC_RAW,
		RSRC_EN,
		RSRC_CNT
	} rdci_rsrc_e;
	rdci_rsrc_e rsrc;

	// byte lanes not selected contribute zeros
	function automatic logic [RDCI_DW-1:0] lane_mask(input logic [RDCI_SEL_W-1:0] sel);
		logic [RDCI_DW-1:0] m;
		m = '0;
		for (int i = 0; i < RDCI_SEL_W; i++) begin
			m[i*8 +: 8] = {8{sel[i]}};
		end
		return m;
	endfunction : lane_mask

	// word decode, low address bits ignored
	function automatic logic hit(input logic [RDCI_ADR_W-1:0] adr,
			input logic [RDCI_ADR_W-1:0] ofs);
		return adr[RDCI_ADR_W-1:2] == ofs[RDCI_ADR_W-1:2];
	endfunction : hit

	function automatic logic [NCH-1:0] set_bits(input logic [NCH-1:0] cur,
			input logic [NCH-1:0] ones);
		return cur | ones;
	endfunction : set_bits

	function automatic logic [NCH-1:0] clr_bits(input logic [NCH-1:0] cur,
			input logic [NCH-1:0] ones);
		return cur & ~ones;
	endfunction : clr_bits

	function automatic logic [NCH-1:0] masked(input logic [NCH-1:0] raw,
			input logic [NCH-1:0] en);
		return raw & en;
	endfunction : masked

	// count wraps modulo its width, no saturation on add
	function automatic logic [CNT_W-1:0] add_count(input logic [CNT_W-1:0] cur,
			input logic [CNT_W-1:0] inc);
		return cur + inc;
	endfunction : add_count

	function automatic logic [RDCI_DW-1:0] place_ch(input logic [NCH-1:0] v);
		logic [RDCI_DW-1:0] w;
		w = '0;
		w[NCH-1:0] = v;
		return w;
	endfunction : place_ch

	function automatic logic [RDCI_DW-1:0] place_cnt(input logic [CNT_W-1:0] v);
		logic [RDCI_DW-1:0] w;
		w = '0;
		w[CNT_W-1:0] = v;
		return w;
	endfunction : place_cnt

	// one request per cycle pair: ack drops after each answer
	assign req = wb_cyc_i & wb_stb_i & ~ack_r;
	assign wr = req & wb_we_i;
	assign rd = req & ~wb_we_i;
	// lanes masked once, shared by every register
	assign wdat = wb_dat_i & lane_mask(wb_sel_i);
	assign wdat_ch = wdat[NCH-1:0];
	assign wdat_cnt = wdat[CNT_W-1:0];

	// address decode, one flag per register
	assign sel_masked = hit(wb_adr_i, RDCI_OFS_MASKED);
	assign sel_raw = hit(wb_adr_i, RDCI_OFS_RAW);
	assign sel_en_set = hit(wb_adr_i, RDCI_OFS_EN_SET);
	assign sel_en_clr = hit(wb_adr_i, RDCI_OFS_EN_CLR);
	assign sel_cnt = hit(wb_adr_i, RDCI_OFS_BUFCNT0);

	// write strobes per register
	assign wr_raw = wr & sel_raw;
	assign wr_en_set = wr & sel_en_set;
	assign wr_en_clr = wr & sel_en_clr;
	assign wr_cnt = wr & sel_cnt;

	always_comb begin
		raw_nxt = raw_r;
		if (wr_raw) begin
			raw_nxt = clr_bits(raw_r, wdat_ch);
		end
		raw_nxt = set_bits(raw_nxt, rx_done_i);
	end

	// raw flag register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			raw_r <= RDCI_RAW_RST;
		end else begin
			raw_r <= raw_nxt;
		end
	end

	always_comb begin
		en_nxt = en_r;
		if (wr_en_set) begin
			en_nxt = set_bits(en_r, wdat_ch);
		end
		if (wr_en_clr) begin
			en_nxt = clr_bits(en_r, wdat_ch);
		end
	end

	// enable register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_r <= RDCI_EN_RST;
		end else begin
			en_r <= en_nxt;
		end
	end

	// same-cycle write and take: add first, then take
	always_comb begin
		cnt_added = cnt_r;
		take_ok = 1'b0;
		cnt_nxt = cnt_r;
		if (wr_cnt) begin
			cnt_added = add_count(cnt_r, wdat_cnt);
		end
		// an empty queue cannot lose a buffer, so no wrap below zero
		take_ok = rx_buf_take_i && (cnt_added != '0);
		if (take_ok) begin
			cnt_nxt = cnt_added - 1'b1;
		end else begin
			cnt_nxt = cnt_added;
		end
	end

	// count register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= RDCI_CNT_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// registered from next state, so irq moves with the flags
	always_comb begin
		irq_nxt = |masked(raw_nxt, en_nxt);
	end

	// interrupt register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// a held strobe is answered every other cycle only
	always_comb begin
		ack_nxt = req;
	end

	// ack register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= ack_nxt;
		end
	end

	always_comb begin
		rsrc = RSRC_NONE;
		if (sel_masked) begin
			rsrc = RSRC_MASKED;
		end else if (sel_raw) begin
			rsrc = RSRC_RAW;
		end else if (sel_en_set || sel_en_clr) begin
			rsrc = RSRC_EN;
		end else if (sel_cnt) begin
			rsrc = RSRC_CNT;
		end
	end

	// read data stands only in the ack cycle; writes answer with zeros
	always_comb begin
		dat_nxt = RDCI_DAT_RST;
		if (rd) begin
			case (rsrc)
				RSRC_MASKED: begin
					dat_nxt = place_ch(masked(raw_r, en_r));
				end
				RSRC_RAW: begin
					dat_nxt = place_ch(raw_r);
				end
				RSRC_EN: begin
					dat_nxt = place_ch(en_r);
				end
				RSRC_CNT: begin
					dat_nxt = place_cnt(cnt_r);
				end
				default: begin
					dat_nxt = RDCI_DAT_RST;
				end
			endcase
		end
	end

	// read data register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= RDCI_DAT_RST;
		end else begin
			dat_r <= dat_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign irq_o = irq_r;
	assign rx_buf_count_o = cnt_r;
endmodule : rdci_top

// ==== tb/rdci_properties.sv ====
// checker for the completion status block
`timescale 1ns/10ps
module rdci_properties (
	input logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, rx_buf_take_i, irq_o,
	input logic [7:0] wb_adr_i,
	input logic [3:0] wb_sel_i, rx_done_i,
	input logic [31:0] wb_dat_i, wb_dat_o,
	input logic [15:0] rx_buf_count_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ack cycles excluded: a held strobe is not a new request
	wire wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	a_raw_sticky: assert property ($fell(irq_o) |-> $past(wr || rst_i))
		else $error("irq fell");
	a_masked_read: assert property (wb_ack_o && $past(!wb_adr_i && !wb_we_i && !rx_done_i)
		|-> (wb_dat_o != 0) == irq_o) else $error("masked");
	a_enable_read: assert property (wb_ack_o && $past(wb_adr_i[7:3] == 5'h01)
		|-> !wb_dat_o[31:4]) else $error("enables");
	a_set_enable: assert property (wr && wb_adr_i == 8'h08 && wb_sel_i[0] && wb_dat_i[0]
		&& rx_done_i[0] |=> irq_o) else $error("set");
	a_clear_enable: assert property (wr && wb_adr_i == 8'h0C && wb_sel_i[0]
		&& wb_dat_i[3:0] == 4'hF |=> !irq_o) else $error("clear");
	a_count_take: assert property (rx_buf_take_i && !wr && rx_buf_count_o != 0
		|=> rx_buf_count_o == $past(rx_buf_count_o) - 16'h1) else $error("take");
	a_irq_cause: assert property ($rose(irq_o) |-> $past(|rx_done_i || wr))
		else $error("irq rose");
	c_irq: cover property (irq_o);
	c_irq_off: cover property ($fell(irq_o));
	c_take: cover property (rx_buf_take_i && rx_buf_count_o != 0);
endmodule : rdci_properties
bind rdci_top rdci_properties u_props (.*);

// ==== tb/rdci_top_tb_top.sv ====
// bench for the completion status block
`timescale 1ns/10ps
module rdci_top_tb_top;
	logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, take = 0, ack, irq;
	logic [3:0] done = 4'h0;
	logic [7:0] adr = 8'h00;
	logic [15:0] cnt;
	logic [31:0] wd = 32'h0, rd, q;
	int n_errors = 0, compares = 0;
	always #4 clk_i = ~clk_i;
	rdci_top DUT (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .rx_done_i(done),
		.rx_buf_take_i(take), .rx_buf_count_o(cnt), .irq_o(irq));
	task chk(input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t exp %h got %h", $time, e, g);
		end
	endtask : chk
	// no cycle count assumed; the watchdog cuts a hang
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		// ack and data stand a whole cycle: look mid-cycle, release after the edge
		do @(negedge clk_i); while (ack !== 1'b1);
		q = rd;
		@(posedge clk_i);
		cyc <= 0;
		@(posedge clk_i);
	endtask : acc
	task rdc(input logic [7:0] a, input logic [31:0] e);
		acc(0, a, 32'h0);
		chk(e, q);
	endtask : rdc
	task tally_and_finish;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	initial begin
		#20000;
		n_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		rdc(8'h00, 32'h0);
		done <= 4'hF;
		@(posedge clk_i);
		done <= 4'h1;
		chk(32'h0, irq);
		acc(1, 8'h08, 32'h5);
		done <= 4'h0;
		rdc(8'h04, 32'hF);
		rdc(8'h08, 32'h5);
		rdc(8'h00, 32'h5);
		chk(32'h1, irq);
		acc(1, 8'h0C, 32'h4);
		rdc(8'h0C, 32'h1);
		acc(1, 8'h04, 32'h1);
		chk(32'h0, irq);
		rdc(8'h04, 32'hE);
		acc(1, 8'h0C, 32'hF);
		rdc(8'h08, 32'h0);
		acc(1, 8'h10, 32'h3);
		acc(1, 8'h10, 32'hFFFF);
		rdc(8'h10, 32'h2);
		take <= 1;
		repeat (3) @(posedge clk_i);
		take <= 0;
		@(posedge clk_i);
		chk(32'h0, cnt);
		rdc(8'h20, 32'h0);
		tally_and_finish();
	end
endmodule : rdci_top_tb_top
